// file: rtl/cpu_status_flag_logic.sv
// Status flag generation, flag banks and branch conditions
`timescale 1ns/100ps

// Function
// - Flag byte layout, bits 3 and 5 unused
// - Primary and alternate flag banks
// - Only C, P/V, Z, S are testable
// - Carry follows add carry or borrow
// - Decimal adjust sets carry when correcting the high digit
// - Circular rotates link both operand ends
// - Left rotates take carry from bit 7
// - Right rotates take carry from bit 0
// - AND, OR, XOR clear carry
// - Set carry forces, complement inverts
// - Additions write one into N
// - Overflow is sign carry-in xor carry-out
// - Subtract overflows only on unlike signs
// - Logic and non-accumulator rotates give even parity
// - Block ops: P/V clear on zero count
// - Vector or refresh load copies interrupt enable
// - Port input sets parity of byte
// - Half-carry from bit 3 or borrow
// - Zero set when result byte zero
// - Sign equals result bit 7
module cpu_status_flag_logic
  import cpu_flag_pkg::*;
(
  input wire logic ref_clk, // Core clock, 250 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic opValid, // Operation strobe from decoder
  input wire flag_op_t opCode, // Operation selector
  input wire logic [7:0] opA, // Accumulator or operand
  input wire logic [7:0] opB, // Second operand
  input wire logic counterZero, // Decremented byte counter is zero
  input wire logic interruptEnableCopy, // Second interrupt enable
  input wire logic [3:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  input wire logic [3:0] byteenable, // Avalon byte enables
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait request
  output logic [7:0] resultByte, // Result of last operation
  output logic opDone, // Pulse after an accepted operation
  output logic condCarry, // Branch condition carry
  output logic condParity, // Branch condition parity/overflow
  output logic condZero, // Branch condition zero
  output logic condSign // Branch condition sign
);

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Add or subtract, returns {carry, half, overflow, result}
  function automatic logic [10:0] addSub(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic cin,
    input logic sub
  );
    logic [7:0] bb;
    logic ci;
    logic [4:0] low;
    logic [7:0] low7;
    logic [8:0] full;
    bb = sub ? ~b : b;
    ci = sub ? ~cin : cin;
    low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    low7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
    full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    // Borrow is the inverted carry of the complement sum
    addSub = {full[8] ^ sub, low[4] ^ sub, low7[7] ^ full[8], full[7:0]};
  endfunction : addSub
  // Rotates and shifts, returns {carry out, result}
  function automatic logic [8:0] shiftOp(
    input flag_op_t op,
    input logic [7:0] a,
    input logic cin
  );
    unique case (op)
      OP_ROTATE_LEFT_THROUGH_CARRY_ACC,
      OP_ROTATE_LEFT_THROUGH_CARRY: shiftOp = {a, cin};
      OP_ROTATE_RIGHT_THROUGH_CARRY_ACC,
      OP_ROTATE_RIGHT_THROUGH_CARRY: shiftOp = {a[0], cin, a[7:1]};
      OP_CIRCULAR_LEFT_ACC,
      OP_CIRCULAR_LEFT: shiftOp = {a, a[7]};
      OP_ARITH_SHIFT_LEFT: shiftOp = {a, 1'b0};
      OP_CIRCULAR_RIGHT_ACC,
      OP_CIRCULAR_RIGHT: shiftOp = {a[0], a[0], a[7:1]};
      OP_ARITH_SHIFT_RIGHT: shiftOp = {a[0], a[7], a[7:1]};
      OP_LOGIC_SHIFT_RIGHT: shiftOp = {a[0], 1'b0, a[7:1]};
      default: shiftOp = {cin, a};
    endcase
  endfunction : shiftOp
  // Even parity gives one
  function automatic logic evenParity(input logic [7:0] v);
    evenParity = ~^v;
  endfunction : evenParity

  // ************************************************************
  // Internal state
  // ************************************************************
  logic [7:0] flags; // Primary flag bank
  logic [7:0] altFlags; // Alternate flag bank
  logic opEnable; // Control bit, ops accepted when set
  logic [7:0] next_flags; // Flags after current operation
  logic [7:0] next_result; // Result of current operation
  logic [10:0] arith; // Adder output
  logic [8:0] rot; // Shifter output
  logic [7:0] bcdFix; // Decimal correction amount
  logic isSub; // Current arithmetic is a subtract
  logic busAccept; // Bus request completes this edge
  logic primaryWrite; // Bus writes primary bank
  logic alternateWrite; // Bus writes alternate bank
  logic opFire; // Operation accepted this edge

  // Bus owns the flag banks in an accepted write to either bank; the op is then dropped
  assign busAccept = (read || write) && !waitrequest;
  assign primaryWrite = write && !waitrequest && byteenable[0]
    && address == ADDR_PRIMARY;
  assign alternateWrite = write && !waitrequest && byteenable[0]
    && address == ADDR_ALTERNATE;
  assign opFire = opValid && opEnable && !primaryWrite
    && !alternateWrite;

  // ************************************************************
  // Flag computation
  // ************************************************************
  // Next flags and result for the presented operation
  always_comb begin
    next_flags = flags;
    next_result = opA;
    isSub = opCode == OP_SUBTRACT || opCode == OP_SUBTRACT_BORROW
      || opCode == OP_BLOCK_SEARCH;
    arith = addSub(opA, opB,
      (opCode == OP_ADD_CARRY || opCode == OP_SUBTRACT_BORROW)
      & flags[FLAG_C], isSub);
    rot = shiftOp(opCode, opA, flags[FLAG_C]);
    bcdFix = 8'h00;
    unique case (opCode)
      OP_ADD, OP_ADD_CARRY, OP_SUBTRACT, OP_SUBTRACT_BORROW: begin
        next_result = arith[7:0];
        next_flags[FLAG_S] = arith[7];
        next_flags[FLAG_Z] = arith[7:0] == 8'h00;
        next_flags[FLAG_H] = arith[9];
        next_flags[FLAG_P] = arith[8];
        next_flags[FLAG_N] = !isSub;
        next_flags[FLAG_C] = arith[10];
      end
      OP_AND, OP_OR, OP_XOR: begin
        // H and N keep their value here
        next_result = (opCode == OP_AND) ? opA & opB
          : (opCode == OP_OR) ? opA | opB
          : opA ^ opB;
        next_flags[FLAG_S] = next_result[7];
        next_flags[FLAG_Z] = next_result == 8'h00;
        next_flags[FLAG_P] = evenParity(next_result);
        next_flags[FLAG_C] = 1'b0;
      end
      OP_ROTATE_LEFT_THROUGH_CARRY_ACC,
      OP_ROTATE_RIGHT_THROUGH_CARRY_ACC,
      OP_CIRCULAR_LEFT_ACC, OP_CIRCULAR_RIGHT_ACC: begin
        // Accumulator forms only move the carry
        next_result = rot[7:0];
        next_flags[FLAG_C] = rot[8];
      end
      OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY,
      OP_CIRCULAR_LEFT, OP_ARITH_SHIFT_LEFT, OP_CIRCULAR_RIGHT,
      OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_RIGHT: begin
        next_result = rot[7:0];
        next_flags[FLAG_S] = rot[7];
        next_flags[FLAG_Z] = rot[7:0] == 8'h00;
        next_flags[FLAG_P] = evenParity(rot[7:0]);
        next_flags[FLAG_C] = rot[8];
      end
      OP_SET_CARRY_OP: begin
        next_flags[FLAG_C] = 1'b1;
      end
      OP_COMPLEMENT_CARRY_OP: begin
        next_flags[FLAG_C] = !flags[FLAG_C];
      end
      OP_DECIMAL_ADJUST_OP: begin
        bcdFix = ((flags[FLAG_H] || opA[3:0] > BCD_DIGIT_MAX) ? BCD_LOW_FIX
          : 8'h00) | ((flags[FLAG_C] || opA > BCD_BYTE_MAX) ? BCD_HIGH_FIX
          : 8'h00);
        // N set means the last arithmetic was an addition
        next_result = flags[FLAG_N] ? opA + bcdFix : opA - bcdFix;
        next_flags[FLAG_S] = next_result[7];
        next_flags[FLAG_Z] = next_result == 8'h00;
        next_flags[FLAG_C] = bcdFix[6];
      end
      OP_BLOCK_COPY: begin
        next_flags[FLAG_P] = !counterZero;
      end
      OP_BLOCK_SEARCH: begin
        // Compare only: accumulator keeps its value
        next_flags[FLAG_S] = arith[7];
        next_flags[FLAG_Z] = arith[7:0] == 8'h00;
        next_flags[FLAG_H] = arith[9];
        next_flags[FLAG_N] = 1'b0;
        next_flags[FLAG_P] = !counterZero;
      end
      OP_LOAD_ACC_FROM_VECTOR_REG, OP_LOAD_ACC_FROM_REFRESH_REG: begin
        next_flags[FLAG_P] = interruptEnableCopy;
      end
      OP_PORT_INPUT: begin
        next_flags[FLAG_S] = opA[7];
        next_flags[FLAG_Z] = opA == 8'h00;
        next_flags[FLAG_P] = evenParity(opA);
      end
      OP_EXCHANGE_FLAGS: begin
        next_flags = altFlags;
      end
      default: next_flags = flags;
    endcase
  end

  // ************************************************************
  // Flag banks
  // ************************************************************
  // Primary bank, bus write wins over an operation
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= FLAG_RESET;
    end else if (primaryWrite) begin
      flags <= writedata[7:0] & FLAG_DEFINED;
    end else if (opFire) begin
      flags <= next_flags & FLAG_DEFINED;
    end
  end
  // Alternate bank, only bus writes and exchanges touch it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      altFlags <= FLAG_RESET;
    end else if (alternateWrite) begin
      altFlags <= writedata[7:0] & FLAG_DEFINED;
    end else if (opFire && opCode == OP_EXCHANGE_FLAGS) begin
      altFlags <= flags;
    end
  end
  // Result byte and completion pulse
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      resultByte <= 8'h00;
      opDone <= 1'b0;
    end else begin
      opDone <= opFire;
      if (opFire) begin
        resultByte <= next_result;
      end
    end
  end

  assign condCarry = flags[FLAG_C];
  assign condParity = flags[FLAG_P];
  assign condZero = flags[FLAG_Z];
  assign condSign = flags[FLAG_S];

  // ************************************************************
  // Avalon-MM slave
  // ************************************************************
  // One wait cycle per request, then a single low cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
    end else if (!waitrequest) begin
      waitrequest <= 1'b1;
    end else if (read || write) begin
      waitrequest <= 1'b0;
    end
  end

  // Read data captured as waitrequest drops; unmapped reads give zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= READ_RESET;
    end else if (read && waitrequest) begin
      unique case (address)
        ADDR_PRIMARY: readdata <= {24'h000000, flags};
        ADDR_ALTERNATE: readdata <= {24'h000000, altFlags};
        ADDR_CONTROL: readdata <= {31'h0, opEnable};
        default: readdata <= READ_RESET;
      endcase
    end
  end

  // Control register, gates operations from the decoder
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      opEnable <= CTRL_ENABLE_RESET;
    end else if (busAccept && write && byteenable[0]
        && address == ADDR_CONTROL) begin
      opEnable <= writedata[0];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // Unused bits stay low
  a_unused_bits_low:
  assert property (@(posedge ref_clk) disable iff (!rst_b)
    (flags & ~FLAG_DEFINED) == 8'h00
    && (altFlags & ~FLAG_DEFINED) == 8'h00)
  else $error("Unused flag bit set");

  a_exchange_banks:
  assert property (@(posedge ref_clk) disable iff (!rst_b)
    opFire && opCode == OP_EXCHANGE_FLAGS |=>
    altFlags == $past(flags) && flags == $past(altFlags))
  else $error("Flag banks not exchanged");

  // Add carry matches nine bit sum
  a_add_carry:
  assert property (@(posedge ref_clk) disable iff (!rst_b)
    opFire && opCode == OP_ADD |=> flags[FLAG_C] ==
    (({1'b0, $past(opA)} + {1'b0, $past(opB)}) > 9'h0ff)
    && flags[FLAG_N])
  else $error("Add carry or N wrong");

  // Subtract overflow on unlike signs only
  a_sub_overflow:
  assert property (@(posedge ref_clk) disable iff (!rst_b)
    opFire && opCode == OP_SUBTRACT |=> flags[FLAG_P] ==
    ($past(opA[7]) != $past(opB[7])
    && resultByte[7] != $past(opA[7])))
  else $error("Subtract overflow wrong");

  // AND clears carry and gives parity
  a_logic_carry:
  assert property (@(posedge ref_clk) disable iff (!rst_b)
    opFire && opCode == OP_AND |=> !flags[FLAG_C]
    && flags[FLAG_P] == ~^($past(opA) & $past(opB)))
  else $error("Logic op carry or parity wrong");

  // Circular left carry from bit 7
  a_left_carry:
  assert property (@(posedge ref_clk) disable iff (!rst_b)
    opFire && opCode == OP_CIRCULAR_LEFT |=>
    flags[FLAG_C] == $past(opA[7]) && resultByte[0] == $past(opA[7]))
  else $error("Left rotate carry wrong");

  // Logic right shift carry from bit 0
  a_right_carry:
  assert property (@(posedge ref_clk) disable iff (!rst_b)
    opFire && opCode == OP_LOGIC_SHIFT_RIGHT |=>
    flags[FLAG_C] == $past(opA[0]) && !resultByte[7])
  else $error("Right shift carry wrong");

  a_complement_carry:
  assert property (@(posedge ref_clk) disable iff (!rst_b)
    opFire && opCode == OP_COMPLEMENT_CARRY_OP |=>
    flags[FLAG_C] != $past(flags[FLAG_C]))
  else $error("Carry not complemented");

  // Block copy tracks the byte counter
  a_block_count:
  assert property (@(posedge ref_clk) disable iff (!rst_b)
    opFire && opCode == OP_BLOCK_COPY |=>
    flags[FLAG_P] == !$past(counterZero)
    && flags[FLAG_C] == $past(flags[FLAG_C]))
  else $error("Block count flag wrong");

  a_vector_load:
  assert property (@(posedge ref_clk) disable iff (!rst_b)
    opFire && opCode == OP_LOAD_ACC_FROM_VECTOR_REG |=>
    condParity == $past(interruptEnableCopy))
  else $error("Interrupt enable not copied");
endmodule : cpu_status_flag_logic

// file: rtl/cpu_flag_pkg.sv
// Constants, register map and operation codes for the status flag block
package cpu_flag_pkg;

  // ************************************************************
  // Flag bit positions
  // ************************************************************
  localparam int FLAG_S = 7; // Sign
  localparam int FLAG_Z = 6; // Zero
  localparam int FLAG_H = 4; // Half-carry
  localparam int FLAG_P = 2; // Parity / overflow
  localparam int FLAG_N = 1; // Add / subtract
  localparam int FLAG_C = 0; // Carry

  // ************************************************************
  // Reset values and masks
  // ************************************************************
  localparam logic [7:0] FLAG_RESET = 8'h00; // Flags after reset
  localparam logic [7:0] FLAG_DEFINED = 8'hd7; // Bits 3 and 5 unused
  localparam logic CTRL_ENABLE_RESET = 1'b1; // Ops accepted at reset
  localparam logic [31:0] READ_RESET = 32'h0000_0000; // Idle read data

  // ************************************************************
  // Register byte offsets on the bus
  // ************************************************************
  localparam logic [3:0] ADDR_PRIMARY = 4'h0; // status_flags
  localparam logic [3:0] ADDR_ALTERNATE = 4'h4; // alternate_status_flags
  localparam logic [3:0] ADDR_CONTROL = 4'h8; // Control, bit 0 enable

  // ************************************************************
  // Decimal adjust constants
  // ************************************************************
  localparam logic [7:0] BCD_LOW_FIX = 8'h06; // Low digit correction
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60; // High digit correction
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9; // Largest legal digit
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99; // Largest legal byte

  // ************************************************************
  // Operation codes from the decoder
  // ************************************************************
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_ADD = 5'h01,
    OP_ADD_CARRY = 5'h02,
    OP_SUBTRACT = 5'h03,
    OP_SUBTRACT_BORROW = 5'h04,
    OP_AND = 5'h05,
    OP_OR = 5'h06,
    OP_XOR = 5'h07,
    OP_ROTATE_LEFT_THROUGH_CARRY_ACC = 5'h08,
    OP_ROTATE_RIGHT_THROUGH_CARRY_ACC = 5'h09,
    OP_ROTATE_LEFT_THROUGH_CARRY = 5'h0a,
    OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h0b,
    OP_CIRCULAR_LEFT_ACC = 5'h0c,
    OP_CIRCULAR_LEFT = 5'h0d,
    OP_ARITH_SHIFT_LEFT = 5'h0e,
    OP_CIRCULAR_RIGHT_ACC = 5'h0f,
    OP_CIRCULAR_RIGHT = 5'h10,
    OP_ARITH_SHIFT_RIGHT = 5'h11,
    OP_LOGIC_SHIFT_RIGHT = 5'h12,
    OP_SET_CARRY_OP = 5'h13,
    OP_COMPLEMENT_CARRY_OP = 5'h14,
    OP_DECIMAL_ADJUST_OP = 5'h15,
    OP_BLOCK_COPY = 5'h16,
    OP_BLOCK_SEARCH = 5'h17,
    OP_LOAD_ACC_FROM_VECTOR_REG = 5'h18,
    OP_LOAD_ACC_FROM_REFRESH_REG = 5'h19,
    OP_PORT_INPUT = 5'h1a,
    OP_EXCHANGE_FLAGS = 5'h1b
  } flag_op_t;

endpackage : cpu_flag_pkg

// file: test/op_issue_model.sv
// Decoder-side model that issues flag operations to the block
`timescale 1ns/100ps
module op_issue_model
  import cpu_flag_pkg::*;
(
  input wire logic ref_clk, // Core clock
  input wire logic rst_b, // Reset, active low
  input wire logic reqValid, // Bench asks for one op
  input wire flag_op_t reqCode, // Requested code
  input wire logic [7:0] reqA, // Requested operand A
  input wire logic [7:0] reqB, // Requested operand B
  input wire logic reqZero, // Requested counter state
  input wire logic reqIe, // Interrupt enable copy level
  output logic opValid, // Strobe to block
  output flag_op_t opCode, // Code to block
  output logic [7:0] opA, // Operand A to block
  output logic [7:0] opB, // Operand B to block
  output logic counterZero, // Counter state to block
  output logic interruptEnableCopy // Enable copy to block
);
  // ************************************************************
  // Issue logic
  // ************************************************************
  // Operands scramble between ops so stale values never look valid
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      opValid <= 1'b0;
      opCode <= OP_NONE;
      opA <= 8'h00;
      opB <= 8'h00;
      counterZero <= 1'b0;
    end else if (reqValid) begin // One-cycle strobe
      opValid <= 1'b1;
      opCode <= reqCode;
      opA <= reqA;
      opB <= reqB;
      counterZero <= reqZero;
    end else begin // Idle: drop strobe and code, invert operands and counter
      opValid <= 1'b0;
      opCode <= OP_NONE;
      opA <= ~opA;
      opB <= ~opB;
      counterZero <= ~counterZero;
    end
  end
  // Enable copy is a level, followed every cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      interruptEnableCopy <= 1'b0;
    end else begin
      interruptEnableCopy <= reqIe;
    end
  end
endmodule : op_issue_model

// file: test/tb.sv
// Self-checking bench for the status flag block
`timescale 1ns/100ps
module tb;
  import cpu_flag_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic ref_clk, rst_b; // Clock and reset
  logic reqValid, reqZero, reqIe; // Requests to the model
  flag_op_t reqCode, opCode; // Codes
  logic [7:0] reqA, reqB, opA, opB; // Operands
  logic opValid, counterZero, interruptEnableCopy; // Model outputs
  logic [3:0] address; // Bus address
  logic read, write, waitrequest; // Bus strobes and stall
  logic [31:0] writedata, readdata, rd; // Bus data
  logic [7:0] resultByte; // Block result
  logic opDone, condCarry, condParity, condZero, condSign; // Status
  int errors, compares; // Counters
  // ************************************************************
  // Instances
  // ************************************************************
  op_issue_model u_model (.ref_clk(ref_clk), .rst_b(rst_b),
    .reqValid(reqValid), .reqCode(reqCode), .reqA(reqA), .reqB(reqB),
    .reqZero(reqZero), .reqIe(reqIe), .opValid(opValid),
    .opCode(opCode), .opA(opA), .opB(opB), .counterZero(counterZero),
    .interruptEnableCopy(interruptEnableCopy));
  cpu_status_flag_logic u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .opValid(opValid), .opCode(opCode), .opA(opA), .opB(opB),
    .counterZero(counterZero),
    .interruptEnableCopy(interruptEnableCopy), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
    .resultByte(resultByte), .opDone(opDone), .condCarry(condCarry),
    .condParity(condParity), .condZero(condZero), .condSign(condSign));
  // Free-running 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin // Report at once
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Branch conditions packed as S Z P C
  function automatic logic [31:0] conds();
    return {28'h0, condSign, condZero, condParity, condCarry};
  endfunction : conds
  // One operation through the model, waits for completion
  task automatic doOp(input flag_op_t c, input logic [7:0] a,
                      input logic [7:0] b, input logic cz, input logic ie);
    int n;
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqCode <= c;
    reqA <= a;
    reqB <= b;
    reqZero <= cz;
    reqIe <= ie;
    @(posedge ref_clk);
    reqValid <= 1'b0;
    for (n = 0; n < 8 && opDone !== 1'b1; n++) @(negedge ref_clk);
    if (opDone !== 1'b1) begin // Bounded wait ran out
      errors++;
      $display("ERROR %0t: operation never completed", $time);
      summarize();
    end
  endtask : doOp
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] adr,
                     input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= adr;
    writedata <= {24'h0, d};
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin // Slave never answered
      errors++;
      $display("ERROR %0t: bus access never answered", $time);
      summarize();
    end
  endtask : bus
  // Operation whose result byte and carry are checked
  task automatic rot(input flag_op_t c, input logic [7:0] a,
                     input logic [7:0] res, input logic cy);
    doOp(c, a, 8'h00, 1'b0, 1'b0);
    check(resultByte, res);
    check(condCarry, cy);
  endtask : rot
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    bus(1'b0, ADDR_PRIMARY, 8'h00);
    check(rd, 32'h0);
    bus(1'b1, ADDR_PRIMARY, 8'hff);
    bus(1'b0, ADDR_PRIMARY, 8'h00);
    check(rd, 32'hd7);
    bus(1'b1, ADDR_ALTERNATE, 8'h01);
    doOp(OP_EXCHANGE_FLAGS, 8'h00, 8'h00, 1'b0, 1'b0);
    bus(1'b0, ADDR_PRIMARY, 8'h00);
    check(rd, 32'h01);
    bus(1'b0, ADDR_ALTERNATE, 8'h00);
    check(rd, 32'hd7);
    bus(1'b1, ADDR_PRIMARY, 8'hd6);
    doOp(OP_SET_CARRY_OP, 8'h00, 8'h00, 1'b0, 1'b0);
    bus(1'b0, ADDR_PRIMARY, 8'h00);
    check(rd, 32'hd7);
    bus(1'b0, 4'hc, 8'h00);
    check(rd, 32'h0);
  endtask : t_regs
  task automatic t_arith();
    doOp(OP_ADD, 8'h78, 8'h69, 1'b0, 1'b0);
    check(resultByte, 8'he1);
    check(conds(), 32'ha);
    bus(1'b0, ADDR_PRIMARY, 8'h00);
    check(rd, 32'h96);
    check({rd[7], rd[6], rd[2], rd[0]}, conds());
    doOp(OP_SUBTRACT, 8'h7f, 8'hc0, 1'b0, 1'b0);
    check(conds(), 32'hb);
    bus(1'b0, ADDR_PRIMARY, 8'h00);
    check(rd, 32'h85);
    doOp(OP_SUBTRACT, 8'h05, 8'h07, 1'b0, 1'b0);
    check(conds(), 32'h9);
    doOp(OP_ADD, 8'hff, 8'h01, 1'b0, 1'b0);
    check(conds(), 32'h5);
    doOp(OP_ADD_CARRY, 8'h00, 8'h00, 1'b0, 1'b0);
    check(resultByte, 8'h01);
    check(conds(), 32'h0);
    doOp(OP_SUBTRACT_BORROW, 8'h00, 8'h00, 1'b0, 1'b0);
    check(conds(), 32'h4);
  endtask : t_arith
  task automatic t_logic();
    doOp(OP_SET_CARRY_OP, 8'h00, 8'h00, 1'b0, 1'b0);
    doOp(OP_AND, 8'hf0, 8'h0f, 1'b0, 1'b0);
    check(conds(), 32'h6);
    doOp(OP_OR, 8'h01, 8'h02, 1'b0, 1'b0);
    check(conds(), 32'h2);
    doOp(OP_XOR, 8'h80, 8'h07, 1'b0, 1'b0);
    check(conds(), 32'ha);
    doOp(OP_OR, 8'h01, 8'h00, 1'b0, 1'b0);
    check(conds(), 32'h0);
  endtask : t_logic
  task automatic t_rotate();
    rot(OP_SET_CARRY_OP, 8'h55, 8'h55, 1'b1);
    rot(OP_ROTATE_LEFT_THROUGH_CARRY, 8'h40, 8'h81, 1'b0);
    rot(OP_ROTATE_RIGHT_THROUGH_CARRY, 8'h01, 8'h00, 1'b1);
    rot(OP_ROTATE_LEFT_THROUGH_CARRY_ACC, 8'h00, 8'h01, 1'b0);
    rot(OP_ROTATE_RIGHT_THROUGH_CARRY_ACC, 8'h01, 8'h00, 1'b1);
    rot(OP_CIRCULAR_LEFT_ACC, 8'h80, 8'h01, 1'b1);
    rot(OP_CIRCULAR_LEFT, 8'h40, 8'h80, 1'b0);
    rot(OP_ARITH_SHIFT_LEFT, 8'hc0, 8'h80, 1'b1);
    rot(OP_CIRCULAR_RIGHT_ACC, 8'h02, 8'h01, 1'b0);
    rot(OP_CIRCULAR_RIGHT, 8'h01, 8'h80, 1'b1);
    rot(OP_ARITH_SHIFT_RIGHT, 8'h80, 8'hc0, 1'b0);
    rot(OP_LOGIC_SHIFT_RIGHT, 8'h81, 8'h40, 1'b1);
    rot(OP_COMPLEMENT_CARRY_OP, 8'h55, 8'h55, 1'b0);
    rot(OP_COMPLEMENT_CARRY_OP, 8'h55, 8'h55, 1'b1);
  endtask : t_rotate
  task automatic t_special();
    doOp(OP_BLOCK_COPY, 8'h00, 8'h00, 1'b1, 1'b0);
    check(condParity, 1'b0);
    doOp(OP_BLOCK_COPY, 8'h00, 8'h00, 1'b0, 1'b0);
    check(condParity, 1'b1);
    doOp(OP_BLOCK_SEARCH, 8'h33, 8'h33, 1'b1, 1'b0);
    check(condParity, 1'b0);
    doOp(OP_LOAD_ACC_FROM_VECTOR_REG, 8'h00, 8'h00, 1'b0, 1'b1);
    check(condParity, 1'b1);
    doOp(OP_LOAD_ACC_FROM_REFRESH_REG, 8'h00, 8'h00, 1'b0, 1'b0);
    check(condParity, 1'b0);
    doOp(OP_PORT_INPUT, 8'h03, 8'h00, 1'b0, 1'b0);
    check(condParity, 1'b1);
    doOp(OP_PORT_INPUT, 8'h07, 8'h00, 1'b0, 1'b0);
    check(condParity, 1'b0);
    doOp(OP_ADD, 8'h99, 8'h01, 1'b0, 1'b0);
    doOp(OP_DECIMAL_ADJUST_OP, 8'h9a, 8'h00, 1'b0, 1'b0);
    check(resultByte, 8'h00);
    check(condCarry, 1'b1);
  endtask : t_special
  // Cleared enable bit: decoder ops dropped, flags untouched
  task automatic t_control();
    bus(1'b0, ADDR_CONTROL, 8'h00);
    check(rd, {31'h0, CTRL_ENABLE_RESET});
    bus(1'b1, ADDR_CONTROL, 8'h00);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqCode <= OP_COMPLEMENT_CARRY_OP;
    @(posedge ref_clk);
    reqValid <= 1'b0;
    // Second negedge is where an accepted op would pulse
    repeat (2) @(negedge ref_clk);
    check(opDone, 1'b0);
    check(condCarry, 1'b1);
    bus(1'b1, ADDR_CONTROL, 8'h01);
    bus(1'b0, ADDR_CONTROL, 8'h00);
    check(rd, 32'h1);
  endtask : t_control
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    errors = 0;
    compares = 0;
    rst_b = 1'b0;
    reqValid = 1'b0;
    reqCode = OP_NONE;
    reqA = 8'h00;
    reqB = 8'h00;
    reqZero = 1'b0;
    reqIe = 1'b0;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_arith();
    t_logic();
    t_rotate();
    t_special();
    t_control();
    summarize();
  end
endmodule : tb
